// ==== inc/vir_consts.svh ====
`ifndef VIR_CONSTS_SVH
`define VIR_CONSTS_SVH

// ==========================================================
// Register map (word offsets on the plain register port)
`define VIR_ADDR_W 4
`define VIR_A_PASSTHRU 4'h0
`define VIR_A_VPEND 4'h1
`define VIR_A_HWCLR 4'h2
`define VIR_A_ROOT_MASK 4'h3
`define VIR_A_GUEST_MASK 4'h4
`define VIR_A_GUEST_SW 4'h5
`define VIR_A_GUEST_CTL 4'h6
`define VIR_A_ROOT_CAUSE 4'h7
`define VIR_A_GUEST_CAUSE 4'h8
`define VIR_A_IRQ_STAT 4'h9
`define VIR_A_IRQ_MASK 4'ha
`define VIR_A_CAPS 4'hb

// ==========================================================
// Field layout and reset values
`define VIR_LINES 6
`define VIR_CAUSE_W 8
`define VIR_LINE_BASE 2
`define VIR_POS_W 3
`define VIR_CTL_TI_LSB 0
`define VIR_CTL_PC_LSB 3
`define VIR_CTL_BEV 6
`define VIR_CTL_IV 7
`define VIR_CTL_VS_LSB 8
`define VIR_VS_W 5
`define VIR_CTL_TMR 13
`define VIR_CTL_W 14
`define VIR_ZERO6 6'h00
`define VIR_ZERO8 8'h00
`define VIR_ZERO14 14'h0000
`define VIR_ZERO32 32'h0000_0000
`define VIR_TI_RST 3'h7
`define VIR_PC_RST 3'h6
`define VIR_EV_W 4
`define VIR_EV_FCHG 0
`define VIR_EV_ROOT 1
`define VIR_EV_GUEST 2
`define VIR_EV_VPCLR 3
`define VIR_ZERO4 4'h0

`endif

// ==== inc/vir_pkg.sv ====
package vir_pkg;
   // Which context wins the interrupt decision
   typedef enum logic [1:0] {VIR_TAKE_NONE, VIR_TAKE_ROOT, VIR_TAKE_GUEST} vir_take_t;
endpackage

// ==== inc/vir_pend_if.sv ====
`timescale 1ns/1ps
`include "vir_consts.svh"
// Pending-bit crossbar between the core and the routing combiner
interface vir_pend_if;
   logic [`VIR_LINES-1:0] lines;
   logic [`VIR_LINES-1:0] passthru;
   logic [`VIR_LINES-1:0] vpend;
   logic [`VIR_LINES-1:0] hwclr;
   logic [`VIR_CAUSE_W-1:0] guest_int;
   logic [`VIR_CAUSE_W-1:0] root_cause;
   logic [`VIR_CAUSE_W-1:0] guest_cause;
   modport core (output lines, passthru, vpend, hwclr, guest_int, input root_cause, guest_cause);
   modport comb (input lines, passthru, vpend, hwclr, guest_int, output root_cause, guest_cause);
endinterface

// ==== hw/vir_route.sv ====
`timescale 1ns/1ps
`include "vir_consts.svh"
// ==========================================================
// Cause pending combiner for root and guest contexts
module vir_route (
   // Pending sources and results
   vir_pend_if.comb p
);
   // Per-line routing of external lines
   always_comb begin
      p.root_cause = `VIR_ZERO8;
      p.guest_cause = p.guest_int;
      for (int n = 0; n < `VIR_LINES; n++) begin
         p.guest_cause[n+`VIR_LINE_BASE] = p.guest_int[n+`VIR_LINE_BASE] |
            (p.lines[n] & p.passthru[n]) | p.vpend[n];
         p.root_cause[n+`VIR_LINE_BASE] = p.lines[n] &
            ~(p.passthru[n] | (p.vpend[n] & p.hwclr[n]));
      end
   end
endmodule

// ==== hw/vir_core.sv ====
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "vir_consts.svh"
// What this block does
// - Root interrupt evaluation always active, even guest.
// - Guest cannot mask root-enabled interrupts.
// - Root-enabled taken in root, else guest.
// - Root interrupt wins over pending guest.
// - Guest pending ORs pass, internal, virtual.
// - Cause write and passthrough work together.
// - Guest timer drives its chosen position.
// - Guest software irq ignores pass-through enables.
// - Six lines; line n is bit n+2.
// - Guest bit = line AND enable OR virtual.
// - Root bit hides passed lines, handed ones only under clear.
// - Hardware clear makes virtual bit hide root.
// - Line drop clears virtual bit if enabled.
// - Virtual and clear support optional, detectable.
// - Guest vector field changes raise exceptions.
module vir_core
   import vir_pkg::*;
#(
   parameter bit HAS_VIRTUAL = 1'b1,
   parameter bit HAS_HWCLR = 1'b1,
   parameter logic [`VIR_LINES-1:0] HWCLR_WMASK = 6'h3f
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // External interrupt pins
   input wire logic [`VIR_LINES-1:0] EXT_IRQ_LINES,
   // Guest internal sources and guest mode
   input wire logic GUEST_TIMER_IRQ,
   input wire logic GUEST_PERFCOUNT_IRQ,
   input wire logic GUEST_MODE,
   // Guest writes to its vector configuration
   input wire logic GUEST_CFG_WR,
   input wire logic [`VIR_CTL_W-1:0] GUEST_CFG_WDATA,
   // Register port
   input wire logic [`VIR_ADDR_W-1:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Interrupt decision
   output logic ROOT_IRQ,
   output logic GUEST_IRQ,
   output logic FIELD_CHANGE_EXC,
   output logic IRQ
);
   // ==========================================================
   // Declarations
   logic [`VIR_LINES-1:0] line_s1_q;
   logic [`VIR_LINES-1:0] line_q;
   logic [`VIR_LINES-1:0] line_prev_q;
   logic [`VIR_LINES-1:0] passthrough_enable_q;
   logic [`VIR_LINES-1:0] virtual_pending_q;
   logic [`VIR_LINES-1:0] hardware_clear_ctl_q;
   logic [`VIR_CAUSE_W-1:0] root_mask_q;
   logic [`VIR_CAUSE_W-1:0] guest_mask_q;
   logic [1:0] guest_sw_q;
   logic [`VIR_CTL_W-1:0] guest_ctl_q;
   logic [`VIR_EV_W-1:0] irq_stat_q;
   logic [`VIR_EV_W-1:0] irq_mask_q;
   logic [`VIR_EV_W-1:0] ev_d;
   logic root_irq_q;
   logic guest_irq_q;
   logic fchg_q;
   logic irq_q;
   logic [31:0] rdata_q;
   logic [`VIR_CAUSE_W-1:0] guest_int_d;
   logic [`VIR_LINES-1:0] vp_drop_d;
   logic fchg_d;
   vir_take_t take_d;
   vir_pend_if pend ();

   // Decode a register write
   function automatic logic wr_hit(input logic [`VIR_ADDR_W-1:0] a);
      return REG_WR && (REG_ADDR == a);
   endfunction

   // One-hot bit at a 3-bit cause position
   function automatic logic [`VIR_CAUSE_W-1:0] pos_bit(input logic [`VIR_POS_W-1:0] p);
      logic [`VIR_CAUSE_W-1:0] r;
      r = `VIR_ZERO8;
      r[p] = 1'b1;
      return r;
   endfunction

   // ==========================================================
   // Pin synchroniser
   // six shared lines sampled
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         line_s1_q <= `VIR_ZERO6;
         line_q <= `VIR_ZERO6;
      end else begin
         line_s1_q <= EXT_IRQ_LINES;
         line_q <= line_s1_q;
      end
   end

   // Settled level one cycle back; reads only the second stage
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         line_prev_q <= `VIR_ZERO6;
      end else begin
         line_prev_q <= line_q;
      end
   end

   // ==========================================================
   // Guest internal sources
   always_comb begin
      // Software bits sit below the line bits, in cause bits 1:0
      guest_int_d = {`VIR_ZERO6, guest_sw_q};
      if (GUEST_TIMER_IRQ) begin
         guest_int_d = guest_int_d |
            pos_bit(guest_ctl_q[`VIR_CTL_TI_LSB +: `VIR_POS_W]);
      end
      if (GUEST_PERFCOUNT_IRQ) begin
         guest_int_d = guest_int_d |
            pos_bit(guest_ctl_q[`VIR_CTL_PC_LSB +: `VIR_POS_W]);
      end
   end

   // Feed the combiner
   // three guest source groups
   assign pend.lines = line_q;
   assign pend.passthru = passthrough_enable_q;
   assign pend.vpend = virtual_pending_q;
   assign pend.hwclr = hardware_clear_ctl_q;
   assign pend.guest_int = guest_int_d;

   vir_route u_route (
      .p(pend.comb)
   );

   // ==========================================================
   // Pass-through enables
   // reset hides nothing from root
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         passthrough_enable_q <= `VIR_ZERO6;
      end else if (wr_hit(`VIR_A_PASSTHRU)) begin
         passthrough_enable_q <= REG_WDATA[`VIR_LINES-1:0];
      end
   end

   // Hardware clear enables, only writable where supported
   // optional clear capability
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         hardware_clear_ctl_q <= `VIR_ZERO6;
      end else if (HAS_HWCLR && wr_hit(`VIR_A_HWCLR)) begin
         hardware_clear_ctl_q <= REG_WDATA[`VIR_LINES-1:0] & HWCLR_WMASK;
      end
   end

   // Falling edge of a line clears its virtual bit under hardware clear
   assign vp_drop_d = line_prev_q & ~line_q & hardware_clear_ctl_q;

   // Virtual pending bits; a write in the drop cycle takes the written value
   // line drop auto-clear
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         virtual_pending_q <= `VIR_ZERO6;
      end else if (HAS_VIRTUAL && wr_hit(`VIR_A_VPEND)) begin
         virtual_pending_q <= REG_WDATA[`VIR_LINES-1:0];
      end else begin
         virtual_pending_q <= virtual_pending_q & ~vp_drop_d;
      end
   end

   // ==========================================================
   // Masks and guest cause software bits
   // root mask only by root port
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         root_mask_q <= `VIR_ZERO8;
         guest_mask_q <= `VIR_ZERO8;
      end else begin
         if (wr_hit(`VIR_A_ROOT_MASK)) begin
            root_mask_q <= REG_WDATA[`VIR_CAUSE_W-1:0];
         end
         if (wr_hit(`VIR_A_GUEST_MASK)) begin
            guest_mask_q <= REG_WDATA[`VIR_CAUSE_W-1:0];
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         guest_sw_q <= 2'h0;
      end else if (wr_hit(`VIR_A_GUEST_SW)) begin
         guest_sw_q <= REG_WDATA[1:0];
      end
   end

   // ==========================================================
   // Guest vector configuration and change detection
   always_comb begin
      fchg_d = 1'b0;
      if (GUEST_CFG_WR) begin
         fchg_d = (GUEST_CFG_WDATA[`VIR_CTL_BEV] != guest_ctl_q[`VIR_CTL_BEV]) ||
            (GUEST_CFG_WDATA[`VIR_CTL_IV] != guest_ctl_q[`VIR_CTL_IV]) ||
            (GUEST_CFG_WDATA[`VIR_CTL_VS_LSB +: `VIR_VS_W] !=
             guest_ctl_q[`VIR_CTL_VS_LSB +: `VIR_VS_W]);
      end
   end

   // Root write wins over a guest write in the same cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         guest_ctl_q <= `VIR_ZERO14;
         guest_ctl_q[`VIR_CTL_TI_LSB +: `VIR_POS_W] <= `VIR_TI_RST;
         guest_ctl_q[`VIR_CTL_PC_LSB +: `VIR_POS_W] <= `VIR_PC_RST;
      end else if (wr_hit(`VIR_A_GUEST_CTL)) begin
         guest_ctl_q <= REG_WDATA[`VIR_CTL_W-1:0];
      end else if (GUEST_CFG_WR) begin
         guest_ctl_q <= GUEST_CFG_WDATA;
      end
   end

   // ==========================================================
   // Take decision
   always_comb begin
      take_d = VIR_TAKE_NONE;
      if (|(pend.root_cause & root_mask_q)) begin
         take_d = VIR_TAKE_ROOT;
      end else if (GUEST_MODE && |(pend.guest_cause & guest_mask_q)) begin
         take_d = VIR_TAKE_GUEST;
      end
   end

   // Decision held in flops so both outputs stay glitch free
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         root_irq_q <= 1'b0;
         guest_irq_q <= 1'b0;
      end else begin
         root_irq_q <= (take_d == VIR_TAKE_ROOT);
         guest_irq_q <= (take_d == VIR_TAKE_GUEST);
      end
   end

   // Field-change pulse, one cycle per changing guest write
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fchg_q <= 1'b0;
      end else begin
         fchg_q <= fchg_d;
      end
   end

   // ==========================================================
   // Sticky event status; set beats write-one-to-clear
   // A take logs only on its rising edge, so a held level logs once
   always_comb begin
      ev_d = `VIR_ZERO4;
      ev_d[`VIR_EV_FCHG] = fchg_d;
      ev_d[`VIR_EV_ROOT] = (take_d == VIR_TAKE_ROOT) & ~root_irq_q;
      ev_d[`VIR_EV_GUEST] = (take_d == VIR_TAKE_GUEST) & ~guest_irq_q;
      ev_d[`VIR_EV_VPCLR] = |vp_drop_d;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_stat_q <= `VIR_ZERO4;
      end else if (wr_hit(`VIR_A_IRQ_STAT)) begin
         irq_stat_q <= (irq_stat_q & ~REG_WDATA[`VIR_EV_W-1:0]) | ev_d;
      end else begin
         irq_stat_q <= irq_stat_q | ev_d;
      end
   end

   // Event mask, same layout as the status
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_mask_q <= `VIR_ZERO4;
      end else if (wr_hit(`VIR_A_IRQ_MASK)) begin
         irq_mask_q <= REG_WDATA[`VIR_EV_W-1:0];
      end
   end

   // Registered level; lags the status by one cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ==========================================================
   // Read port, data valid the cycle after the strobe
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= `VIR_ZERO32;
      end else if (REG_RD) begin
         rdata_q <= `VIR_ZERO32;
         unique case (REG_ADDR)
            `VIR_A_PASSTHRU: rdata_q[`VIR_LINES-1:0] <= passthrough_enable_q;
            `VIR_A_VPEND: rdata_q[`VIR_LINES-1:0] <= virtual_pending_q;
            `VIR_A_HWCLR: rdata_q[`VIR_LINES-1:0] <= hardware_clear_ctl_q;
            `VIR_A_ROOT_MASK: rdata_q[`VIR_CAUSE_W-1:0] <= root_mask_q;
            `VIR_A_GUEST_MASK: rdata_q[`VIR_CAUSE_W-1:0] <= guest_mask_q;
            `VIR_A_GUEST_SW: rdata_q[1:0] <= guest_sw_q;
            `VIR_A_GUEST_CTL: rdata_q[`VIR_CTL_W-1:0] <= guest_ctl_q;
            `VIR_A_ROOT_CAUSE: rdata_q[`VIR_CAUSE_W-1:0] <= pend.root_cause;
            `VIR_A_GUEST_CAUSE: rdata_q[`VIR_CAUSE_W-1:0] <= pend.guest_cause;
            `VIR_A_IRQ_STAT: rdata_q[`VIR_EV_W-1:0] <= irq_stat_q;
            `VIR_A_IRQ_MASK: rdata_q[`VIR_EV_W-1:0] <= irq_mask_q;
            `VIR_A_CAPS: rdata_q[1:0] <= {HAS_HWCLR, HAS_VIRTUAL};
            // Unmapped words read as zero
            default: rdata_q <= `VIR_ZERO32;
         endcase
      end else begin
         rdata_q <= `VIR_ZERO32;
      end
   end

   // ==========================================================
   // Outputs straight from flops
   assign REG_RDATA = rdata_q;
   assign ROOT_IRQ = root_irq_q;
   assign GUEST_IRQ = guest_irq_q;
   assign FIELD_CHANGE_EXC = fchg_q;
   assign IRQ = irq_q;
endmodule

// ==== verification/vir_core_monitor.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checks of the routing core
module vir_core_monitor (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Watched inputs
   input wire logic GUEST_MODE,
   input wire logic GUEST_CFG_WR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   // Watched outputs
   input wire logic [31:0] REG_RDATA,
   input wire logic ROOT_IRQ,
   input wire logic GUEST_IRQ,
   input wire logic FIELD_CHANGE_EXC,
   input wire logic IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // Read strobe then a quiet cycle
   sequence s_rd_done;
      REG_RD ##1 !REG_RD;
   endsequence
   // Exception pulse with no fresh guest write
   sequence s_exc_lone;
      FIELD_CHANGE_EXC && !GUEST_CFG_WR;
   endsequence

   a_rdata_once: assert property (s_rd_done |=> REG_RDATA == 32'h0)
      else $error("read data held too long");
   a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
      else $error("read data without read");
   a_root_wins: assert property (ROOT_IRQ |-> !GUEST_IRQ)
      else $error("guest irq beside root irq");
   a_guest_mode_only: assert property (GUEST_IRQ |-> $past(GUEST_MODE))
      else $error("guest irq outside guest mode");
   a_guest_mode_off: assert property ($fell(GUEST_MODE) |=> !GUEST_IRQ)
      else $error("guest irq after mode exit");
   a_exc_cause: assert property (FIELD_CHANGE_EXC |-> $past(GUEST_CFG_WR))
      else $error("field change without guest write");
   a_exc_pulse: assert property (s_exc_lone |=> !FIELD_CHANGE_EXC)
      else $error("field change pulse too long");
   a_reset_quiet: assert property ($fell(RST) |-> !(ROOT_IRQ || GUEST_IRQ || IRQ))
      else $error("irq output live after reset");
endmodule

bind vir_core vir_core_monitor mon_u (.CLK(CLK), .RST(RST), .GUEST_MODE(GUEST_MODE),
   .GUEST_CFG_WR(GUEST_CFG_WR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .ROOT_IRQ(ROOT_IRQ), .GUEST_IRQ(GUEST_IRQ), .FIELD_CHANGE_EXC(FIELD_CHANGE_EXC), .IRQ(IRQ));

// ==== verification/vir_ext_src.sv ====
`timescale 1ns/1ps
// ==========================================
// External line model, changes only after an edge
module vir_ext_src (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Requested and driven levels
   input wire logic [5:0] want,
   output logic [5:0] lines
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lines <= 6'h00;
      end else begin
         lines <= want;
      end
   end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "vir_consts.svh"
// ==========================================
// Self-checking bench of the routing core
module tb_top;
   logic clk, rst, tmr, pc, gmode, cfg_wr, wr_s, rd_s, root_irq, guest_irq, fexc, irq;
   logic [5:0] want, lines, ln, pt, hc, vp;
   logic [13:0] cfg_wd;
   logic [3:0] addr;
   logic [31:0] wd, rdata, v;
   integer seed, n_mismatch, check_count, cycles, nexc, i;

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   vir_ext_src src_u (.clk(clk), .rst(rst), .want(want), .lines(lines));
   vir_core dut_u (.CLK(clk), .RST(rst), .EXT_IRQ_LINES(lines), .GUEST_TIMER_IRQ(tmr),
      .GUEST_PERFCOUNT_IRQ(pc), .GUEST_MODE(gmode), .GUEST_CFG_WR(cfg_wr),
      .GUEST_CFG_WDATA(cfg_wd), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr_s),
      .REG_RD(rd_s), .REG_RDATA(rdata), .ROOT_IRQ(root_irq), .GUEST_IRQ(guest_irq),
      .FIELD_CHANGE_EXC(fexc), .IRQ(irq));

   // Expected pending bits n+2, per line
   function automatic logic [5:0] exp_g(input logic [5:0] l, p, q);
      return (l & p) | q;
   endfunction
   function automatic logic [5:0] exp_r(input logic [5:0] l, p, q, h);
      return l & ~(p | (q & h));
   endfunction

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic ext(input logic [5:0] w);
      @(posedge clk);
      want <= w;
      settle;
   endtask
   task automatic gwr(input logic [13:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_wd <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      settle;
   endtask
   task automatic finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Hang guard and field-change pulse count
   always @(posedge clk) begin
      cycles++;
      if (fexc === 1'b1) nexc++;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end

   initial begin
      seed = 32'hb9ca;
      {n_mismatch, check_count, cycles, nexc} = '0;
      {tmr, pc, gmode, cfg_wr, wr_s, rd_s, want, cfg_wd, addr, wd} = '0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // routing fields clear, fixed reset values
      for (i = 0; i < 3; i++) begin
         rd(i[3:0]);
         chk(v, 32'h0);
      end
      rd(`VIR_A_GUEST_CTL);
      chk(v, 32'h37);
      rd(`VIR_A_CAPS);
      chk(v, 32'h3);
      rd(4'hf);
      chk(v, 32'h0);
      // both contexts stay non-EXTERNAL_INTERRUPT_CONTROLLER, pass-through allowed
      // random routing, first pass lines 0, 2 and 4 handed over
      for (i = 0; i < 24; i++) begin
         v = $random(seed);
         {vp, hc, pt, ln} = v[23:0];
         if (i == 0) {vp, hc, pt, ln} = {6'h15, 6'h3f, 6'h00, 6'h3f};
         ext(ln);
         wr(`VIR_A_PASSTHRU, {26'h0, pt});
         wr(`VIR_A_HWCLR, {26'h0, hc});
         wr(`VIR_A_VPEND, {26'h0, vp});
         settle;
         rd(`VIR_A_ROOT_CAUSE);
         chk({26'h0, v[7:2]}, {26'h0, exp_r(ln, pt, vp, hc)});
         rd(`VIR_A_GUEST_CAUSE);
         chk({26'h0, v[7:2]}, {26'h0, exp_g(ln, pt, vp)});
      end
      // line drop clears handed bit and flags it
      ext(6'h01);
      wr(`VIR_A_PASSTHRU, 32'h0);
      wr(`VIR_A_IRQ_STAT, 32'hf);
      wr(`VIR_A_HWCLR, 32'h1);
      wr(`VIR_A_VPEND, 32'h1);
      ext(6'h00);
      rd(`VIR_A_VPEND);
      chk(v, 32'h0);
      rd(`VIR_A_IRQ_STAT);
      chk(v & 32'h8, 32'h8);
      chk({31'h0, irq}, 32'h0);
      wr(`VIR_A_IRQ_MASK, 32'h8);
      settle;
      chk({31'h0, irq}, 32'h1);
      wr(`VIR_A_IRQ_STAT, 32'h8);
      settle;
      chk({31'h0, irq}, 32'h0);
      // without hardware clear the bit stays
      wr(`VIR_A_HWCLR, 32'h0);
      ext(6'h01);
      wr(`VIR_A_VPEND, 32'h1);
      settle;
      rd(`VIR_A_ROOT_CAUSE);
      chk(v & 32'h4, 32'h4);
      ext(6'h00);
      rd(`VIR_A_VPEND);
      chk(v, 32'h1);
      wr(`VIR_A_VPEND, 32'h0);
      rd(`VIR_A_VPEND);
      chk(v, 32'h0);
      @(posedge clk);
      tmr <= 1'b1;
      pc <= 1'b1;
      settle;
      rd(`VIR_A_GUEST_CAUSE);
      chk(v & 32'hfc, 32'hc0);
      wr(`VIR_A_PASSTHRU, 32'h3f);
      wr(`VIR_A_GUEST_CTL, 32'h23);
      settle;
      rd(`VIR_A_GUEST_CAUSE);
      chk(v & 32'hfc, 32'h18);
      // Root-written software bits land in cause bits 1:0 only
      wr(`VIR_A_GUEST_SW, 32'h3);
      rd(`VIR_A_GUEST_CAUSE);
      chk(v & 32'hc3, 32'h3);
      wr(`VIR_A_GUEST_SW, 32'h0);
      @(posedge clk);
      tmr <= 1'b0;
      pc <= 1'b0;
      wr(`VIR_A_PASSTHRU, 32'h0);
      wr(`VIR_A_ROOT_MASK, 32'hff);
      @(posedge clk);
      gmode <= 1'b1;
      ext(6'h02);
      chk({30'h0, root_irq, guest_irq}, 32'h2);
      wr(`VIR_A_GUEST_MASK, 32'hff);
      wr(`VIR_A_PASSTHRU, 32'h2);
      settle;
      chk({30'h0, root_irq, guest_irq}, 32'h1);
      ext(6'h06);
      chk({30'h0, root_irq, guest_irq}, 32'h2);
      ext(6'h02);
      @(posedge clk);
      gmode <= 1'b0;
      settle;
      chk({30'h0, root_irq, guest_irq}, 32'h0);
      // only vector field changes raise exceptions
      gwr(14'h0063);
      gwr(14'h0063);
      gwr(14'h0163);
      gwr(14'h0164);
      chk(nexc, 32'h2);
      // Status logged field change, root take and guest take
      rd(`VIR_A_IRQ_STAT);
      chk(v, 32'h7);
      chk({31'h0, irq}, 32'h0);
      finish_test;
   end
endmodule
